/* File: include/hda_pkg.sv */
// Constants, codes and types of the heater diagnostic annunciator
`default_nettype none
package hda_pkg;
  // Clock and the 1 ms time base
  localparam int unsigned CLK_HZ       = 200_000_000;  // mclk rate
  localparam int unsigned T_TICK_MS    = 1;            // time base period, ms
  localparam int unsigned MS_CYC       = CLK_HZ / 1000 * T_TICK_MS; // cycles per tick

  // Times in their own units, as printed
  localparam int unsigned T_DATA_HOLD_S  = 1;    // start held to request data codes
  localparam int unsigned T_PURGE_HOLD_S = 10;   // start held to request a manual purge
  localparam int unsigned T_OFF_S        = 2;    // switch off before purge begins
  localparam int unsigned T_IGN_HALF_MIN = 7;    // 3.5 min ignition allowance, in half minutes
  localparam int unsigned T_PURGE_MIN    = 3;    // whole purge cycle
  localparam int unsigned T_PCODE_MIN    = 1;    // purge code shown before data codes
  localparam int unsigned T_GROUP_S      = 1;    // one displayed group
  localparam int unsigned T_BLANK_S      = 1;    // blank gap between groups
  localparam int unsigned T_DARK_S       = 2;    // dark delay after a flash burst
  localparam int unsigned T_QUICK_MS     = 250;  // quick flash on and off time
  localparam int unsigned T_ALT_S        = 1;    // warning/run code alternation

  // Timers count time-base ticks
  typedef logic [17:0] hda_ms_t;
  localparam hda_ms_t DATA_HOLD_MS  = hda_ms_t'(T_DATA_HOLD_S * 1000);
  localparam hda_ms_t PURGE_HOLD_MS = hda_ms_t'(T_PURGE_HOLD_S * 1000);
  localparam hda_ms_t OFF_MS        = hda_ms_t'(T_OFF_S * 1000);
  localparam hda_ms_t IGN_MS        = hda_ms_t'(T_IGN_HALF_MIN * 30_000);
  localparam hda_ms_t PURGE_MS      = hda_ms_t'(T_PURGE_MIN * 60_000);
  localparam hda_ms_t PCODE_MS      = hda_ms_t'(T_PCODE_MIN * 60_000);
  localparam hda_ms_t GROUP_MS      = hda_ms_t'(T_GROUP_S * 1000);
  localparam hda_ms_t BLANK_MS      = hda_ms_t'(T_BLANK_S * 1000);
  localparam hda_ms_t DARK_MS       = hda_ms_t'(T_DARK_S * 1000);
  localparam hda_ms_t QUICK_MS      = hda_ms_t'(T_QUICK_MS);
  localparam hda_ms_t ALT_MS        = hda_ms_t'(T_ALT_S * 1000);

  // Display codes
  localparam logic [7:0] CODE_PURGE = 8'h00;
  localparam logic [7:0] CODE_LOW   = 8'h07;
  localparam logic [7:0] CODE_HIGH  = 8'h14;
  localparam logic [7:0] F_SENSOR   = 8'hC7;  // fuel pressure sensor warning
  localparam logic [7:0] F_LOWP     = 8'hE2;  // low fuel pressure warning
  localparam logic [7:0] F_VOLT     = 8'hE6;  // system voltage fault
  localparam logic [7:0] F_IGN      = 8'hF1;  // ignition overtime
  localparam logic [3:0] ITER_LOWER = 4'h3;   // iteration that brings lower case d

  // Glyphs: 0..F hex digits, then extras
  localparam logic [4:0] GLY_D_UP  = 5'h0D;
  localparam logic [4:0] GLY_BLANK = 5'h10;
  localparam logic [4:0] GLY_D_LO  = 5'h11;
  localparam logic [2:0] LAST_GRP  = 3'h7;   // eight groups per playback

  // Reset values
  localparam logic [3:0] ITER_RST  = 4'h0;

  typedef enum logic [2:0] {
    M_OFF   = 3'b000,
    M_DATA  = 3'b001,
    M_START = 3'b010,
    M_RUN   = 3'b011,
    M_PURGE = 3'b100
  } hda_mode_t;
endpackage
`default_nettype wire

/* File: logic/hda_annunciator.sv */
// Diagnostic display and control-box lamp annunciator of the heater controller
// Behaviour
// - Start held 1 s, released off: data playback
// - Hours: code, high pair, low pair
// - Starts: code, high pair, low pair
// - Version: code then one two-digit number
// - Minute after switch-off, play hours, starts, version
// - One second blank between playback groups
// - Iteration 3 or later shows lower-case d
// - Startup fault or ignition timeout: purge, flash, code
// - Run warning alternates fault and run code
// - Run warning: compensate where possible
// - Unrecoverable warning: purge, code shown steadily
// - Warnings do not flash, except fuel pressure
// - Low pressure: two quick flashes, 2 s dark
// - Sensor warning: three quick flashes, 2 s dark
// - Shutdown fault: stop heat, enter purge at once
// - Shutdown fault: show code, one flash, 2 s dark
// - Warning code encodings fixed
// - Shutdown code encodings fixed
// - Voltage code shown only from iteration 3
// - Run shows low or high heat code
// - Switch off over 2 s: purge, then off
// - Purge 3 min: 00 first minute, then data
`timescale 1ns/1ps
`default_nettype none
module hda_annunciator #(
  parameter int unsigned MS_CYC = hda_pkg::MS_CYC  // cycles per 1 ms tick
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       switch_start,       // Control switch in start, pin
  input  wire logic       switch_run,         // Control switch in run, pin
  input  wire logic       heat_level_switch,  // High heat when set, pin
  input  wire logic [3:0] design_iteration,   // Board iteration strap
  input  wire logic [15:0] hours_bcd,         // Four-digit hour total
  input  wire logic [15:0] starts_bcd,        // Four-digit start count
  input  wire logic [7:0] version_bcd,        // Two-digit software version
  input  wire logic       fault_pulse,        // One fault occurrence
  input  wire logic [7:0] fault_code,         // Its code
  input  wire logic       fault_shutdown,     // Set for a shutdown fault
  input  wire logic       warn_fatal,         // Warning no longer compensable
  input  wire logic       ignition_done,      // Flame established pulse
  output logic       [4:0] disp_hi,           // Left character glyph
  output logic       [4:0] disp_lo,           // Right character glyph
  output logic             lamp,              // Control-box lamp
  output logic             heat_stop,         // Burner must not heat
  output logic             purge_active,      // Purge cycle running
  output logic             compensate,        // Run-time warning adjustment
  output logic             power_off          // Self shut-off pulse
);

  // Every flip-flop of the block
  typedef struct packed {
    logic [2:0]         s_start;    // Synchroniser chains
    logic [2:0]         s_run;
    logic [2:0]         s_heat;
    logic               start_st;   // Agreed switch levels
    logic               run_st;
    logic               heat_st;
    logic [3:0]         iter;       // Captured strap
    logic               iter_ok;
    hda_pkg::hda_ms_t   div;        // Tick divider
    logic               tick;
    hda_pkg::hda_mode_t mode;
    hda_pkg::hda_ms_t   sw_ms;      // Switch hold or off time
    hda_pkg::hda_ms_t   mode_ms;    // Time in current mode
    logic [2:0]         grp;        // Playback group
    logic               gap;        // Blank phase of playback
    hda_pkg::hda_ms_t   grp_ms;
    logic [7:0]         warn_code;  // Latched warning
    logic               warn_v;
    logic [7:0]         sd_code;    // Latched shutdown fault
    logic               sd_v;
    logic               fault_purge; // Purge caused by a fault
    logic               alt;        // Alternation phase
    hda_pkg::hda_ms_t   alt_ms;
    logic               fl_on;      // Flash sequencer
    logic               fl_dark;
    logic [1:0]         fl_i;
    hda_pkg::hda_ms_t   fl_ms;
    logic [4:0]         disp_hi;
    logic [4:0]         disp_lo;
    logic               lamp;
    logic               heat_stop;
    logic               purge;
    logic               comp;
    logic               power_off;
  } hda_state_t;

  hda_state_t q;            // Registered state
  hda_state_t d;            // Next state
  logic       sw_act;       // Switch timer should run
  logic       go_purge;     // Enter purge this cycle
  logic       go_fault;     // That purge is fault driven
  logic       seq_run;      // Playback sequencer enabled
  logic       lower;        // Lower-case item letter
  logic [7:0] show;         // Code for the display
  logic       show_code;    // Display shows a code, not playback
  logic [1:0] fl_n;         // Flashes per burst, zero for none
  logic [9:0] seq_gl;       // Playback glyph pair

  // Code byte to two glyphs, hiding the voltage code on old boards
  function automatic logic [9:0] code_glyphs(input logic [7:0] c, input logic new_hw);
    if (c == hda_pkg::F_VOLT && !new_hw)
      code_glyphs = {hda_pkg::GLY_BLANK, hda_pkg::GLY_BLANK};
    else
      code_glyphs = {1'b0, c[7:4], 1'b0, c[3:0]};
  endfunction

  // Warning codes that flash the lamp, with their burst length
  function automatic logic [1:0] warn_flashes(input logic [7:0] c);
    if (c == hda_pkg::F_SENSOR)
      warn_flashes = 2'd3;
    else if (c == hda_pkg::F_LOWP)
      warn_flashes = 2'd2;
    else
      warn_flashes = 2'd0;
  endfunction

  always_comb
  begin
    d         = q;
    go_purge  = 1'b0;
    go_fault  = 1'b0;
    lower     = q.iter >= hda_pkg::ITER_LOWER;
    seq_gl    = {hda_pkg::GLY_BLANK, hda_pkg::GLY_BLANK};
    show      = hda_pkg::CODE_PURGE;
    show_code = 1'b0;
    fl_n      = 2'd0;
    d.power_off = 1'b0;

    // Pins: a change counts once second and third stages agree
    d.s_start = {q.s_start[1:0], switch_start};
    d.s_run   = {q.s_run[1:0], switch_run};
    d.s_heat  = {q.s_heat[1:0], heat_level_switch};
    if (q.s_start[1] == q.s_start[2])
      d.start_st = q.s_start[2];
    if (q.s_run[1] == q.s_run[2])
      d.run_st = q.s_run[2];
    if (q.s_heat[1] == q.s_heat[2])
      d.heat_st = q.s_heat[2];
    // Strap is caught once, on the first edge after release
    if (!q.iter_ok)
    begin
      d.iter    = design_iteration;
      d.iter_ok = 1'b1;
    end

    // 1 ms time base
    d.tick = 1'b0;
    if (q.div == hda_pkg::hda_ms_t'(MS_CYC - 1))
    begin
      d.div  = '0;
      d.tick = 1'b1;
    end
    else
      d.div = q.div + 1'b1;

    // Switch timer: start hold when off, off time when heating
    if (q.mode == hda_pkg::M_OFF)
      sw_act = q.start_st;
    else if (q.mode == hda_pkg::M_START || q.mode == hda_pkg::M_RUN)
      sw_act = !q.start_st && !q.run_st;
    else
      sw_act = 1'b0;
    if (!sw_act)
      d.sw_ms = '0;
    else if (q.tick && q.sw_ms != '1)
      d.sw_ms = q.sw_ms + 1'b1;

    // Fault latches; no clear other than leaving purge, so none is lost
    if (fault_pulse && fault_shutdown)
    begin
      d.sd_v    = 1'b1;
      d.sd_code = fault_code;
    end
    else if (fault_pulse)
    begin
      d.warn_v    = 1'b1;
      d.warn_code = fault_code;
    end

    // Mode sequencing
    unique case (q.mode)
      hda_pkg::M_OFF:
      begin
        // Decision taken on the release of start
        if (!q.start_st && q.sw_ms != '0)
        begin
          if (q.run_st)
            d.mode = hda_pkg::M_START;
          else if (q.sw_ms >= hda_pkg::PURGE_HOLD_MS)
            go_purge = 1'b1;
          else if (q.sw_ms >= hda_pkg::DATA_HOLD_MS)
            d.mode = hda_pkg::M_DATA;
        end
      end
      hda_pkg::M_DATA:
      begin
        // Leaves after the last group, in the sequencer below
      end
      hda_pkg::M_START:
      begin
        if (fault_pulse && fault_shutdown)
          go_fault = 1'b1;
        else if (fault_pulse && warn_flashes(fault_code) != 2'd0)
          go_fault = 1'b1;
        else if (q.mode_ms >= hda_pkg::IGN_MS)
        begin
          d.sd_v    = 1'b1;
          d.sd_code = hda_pkg::F_IGN;
          go_fault  = 1'b1;
        end
        else if (ignition_done)
          d.mode = hda_pkg::M_RUN;
        else if (q.sw_ms > hda_pkg::OFF_MS)
          go_purge = 1'b1;
      end
      hda_pkg::M_RUN:
      begin
        if (fault_pulse && fault_shutdown)
          go_fault = 1'b1;
        else if (warn_fatal && q.warn_v)
          go_fault = 1'b1;
        else if (q.sw_ms > hda_pkg::OFF_MS)
          go_purge = 1'b1;
      end
      hda_pkg::M_PURGE:
      begin
        // Switch ignored until the purge cycle completes
        if (fault_pulse && fault_shutdown)
          d.fault_purge = 1'b1;
        if (q.mode_ms >= hda_pkg::PURGE_MS)
        begin
          d.mode        = hda_pkg::M_OFF;
          d.power_off   = 1'b1;
          d.fault_purge = 1'b0;
          // A fault taken in this very cycle stays latched: set beats clear
          d.warn_v      = fault_pulse && !fault_shutdown;
          d.sd_v        = fault_pulse && fault_shutdown;
        end
      end
      default:
        d.mode = hda_pkg::M_OFF;
    endcase
    if (go_purge || go_fault)
    begin
      d.mode        = hda_pkg::M_PURGE;
      d.fault_purge = go_fault;
    end

    // Time in mode restarts on every change except the playback's exit to off, set below
    if (d.mode != q.mode)
      d.mode_ms = '0;
    else if (q.tick && q.mode_ms != '1)
      d.mode_ms = q.mode_ms + 1'b1;

    // Playback: 1 s group, 1 s blank, eight groups
    seq_run = q.mode == hda_pkg::M_DATA
           || (q.mode == hda_pkg::M_PURGE && !q.fault_purge
               && q.mode_ms >= hda_pkg::PCODE_MS);
    if (!seq_run)
    begin
      d.grp    = '0;
      d.gap    = 1'b0;
      d.grp_ms = '0;
    end
    else if (q.tick)
    begin
      d.grp_ms = q.grp_ms + 1'b1;
      if (!q.gap && q.grp_ms == hda_pkg::GROUP_MS - 1'b1)
      begin
        d.grp_ms = '0;
        d.gap    = 1'b1;
      end
      else if (q.gap && q.grp_ms == hda_pkg::BLANK_MS - 1'b1)
      begin
        d.grp_ms = '0;
        d.gap    = 1'b0;
        d.grp    = q.grp + 1'b1;
        if (q.grp == hda_pkg::LAST_GRP && q.mode == hda_pkg::M_DATA)
          d.mode = hda_pkg::M_OFF;
      end
    end
    // Group contents: hours, starts, version, high pair first
    // Gated by the sequencer so an idle display stays blank
    if (seq_run && !q.gap)
    begin
      unique case (q.grp)
        3'd0: seq_gl = {lower ? hda_pkg::GLY_D_LO : hda_pkg::GLY_D_UP, 5'h01};
        3'd1: seq_gl = code_glyphs(hours_bcd[15:8], 1'b1);
        3'd2: seq_gl = code_glyphs(hours_bcd[7:0], 1'b1);
        3'd3: seq_gl = {lower ? hda_pkg::GLY_D_LO : hda_pkg::GLY_D_UP, 5'h02};
        3'd4: seq_gl = code_glyphs(starts_bcd[15:8], 1'b1);
        3'd5: seq_gl = code_glyphs(starts_bcd[7:0], 1'b1);
        3'd6: seq_gl = {lower ? hda_pkg::GLY_D_LO : hda_pkg::GLY_D_UP, 5'h03};
        3'd7: seq_gl = code_glyphs(version_bcd, 1'b1);
      endcase
    end

    // Alternation timer for run warnings
    if (q.mode != hda_pkg::M_RUN || !q.warn_v)
    begin
      d.alt    = 1'b0;
      d.alt_ms = '0;
    end
    else if (q.tick)
    begin
      d.alt_ms = q.alt_ms + 1'b1;
      if (q.alt_ms == hda_pkg::ALT_MS - 1'b1)
      begin
        d.alt_ms = '0;
        d.alt    = !q.alt;
      end
    end

    // Display selection, shutdown code ahead of warning
    unique case (q.mode)
      hda_pkg::M_RUN:
      begin
        show_code = 1'b1;
        if (q.warn_v && q.alt)
          show = q.warn_code;
        else
          show = q.heat_st ? hda_pkg::CODE_HIGH : hda_pkg::CODE_LOW;
      end
      hda_pkg::M_PURGE:
      begin
        if (q.fault_purge)
        begin
          show_code = 1'b1;
          show = q.sd_v ? q.sd_code : q.warn_code;
        end
        else if (!seq_run)
          show_code = 1'b1;
      end
      default:
        show_code = 1'b0;
    endcase
    if (show_code)
      {d.disp_hi, d.disp_lo} = code_glyphs(show, lower);
    else
      {d.disp_hi, d.disp_lo} = seq_gl;

    // Lamp cadence, shutdown first
    if (q.mode == hda_pkg::M_START || q.mode == hda_pkg::M_RUN
        || q.fault_purge)
    begin
      if (q.sd_v)
        fl_n = 2'd1;
      else if (q.warn_v)
        fl_n = warn_flashes(q.warn_code);
    end
    if (fl_n == 2'd0)
    begin
      d.fl_on   = 1'b1;
      d.fl_dark = 1'b0;
      d.fl_i    = '0;
      d.fl_ms   = '0;
      d.lamp    = q.mode == hda_pkg::M_RUN;
    end
    else
    begin
      d.lamp = q.fl_on;
      if (q.tick)
      begin
        d.fl_ms = q.fl_ms + 1'b1;
        if (q.fl_dark && q.fl_ms == hda_pkg::DARK_MS - 1'b1)
        begin
          d.fl_ms   = '0;
          d.fl_dark = 1'b0;
          d.fl_on   = 1'b1;
          d.fl_i    = '0;
        end
        else if (!q.fl_dark && q.fl_ms == hda_pkg::QUICK_MS - 1'b1)
        begin
          d.fl_ms = '0;
          d.fl_on = !q.fl_on;
          if (q.fl_on && q.fl_i == fl_n - 2'd1)
            d.fl_dark = 1'b1;
          else if (!q.fl_on)
            d.fl_i = q.fl_i + 2'd1;
        end
      end
    end

    // Lamp dark once idle; the cadence above lags the mode by one cycle
    if (d.mode == hda_pkg::M_OFF || d.mode == hda_pkg::M_DATA)
      d.lamp = 1'b0;

    // Heater-facing levels
    d.heat_stop = !(d.mode == hda_pkg::M_START || d.mode == hda_pkg::M_RUN);
    d.purge     = d.mode == hda_pkg::M_PURGE;
    d.comp      = d.mode == hda_pkg::M_RUN && d.warn_v;
  end

  // Single state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q           <= '0;
      q.iter      <= hda_pkg::ITER_RST;
      q.mode      <= hda_pkg::M_OFF;
      q.fl_on     <= 1'b1;
      q.disp_hi   <= hda_pkg::GLY_BLANK;
      q.disp_lo   <= hda_pkg::GLY_BLANK;
      q.heat_stop <= 1'b1;
    end
    else
      q <= d;
  end

  // Outputs straight from flip-flops
  assign disp_hi      = q.disp_hi;
  assign disp_lo      = q.disp_lo;
  assign lamp         = q.lamp;
  assign heat_stop    = q.heat_stop;
  assign purge_active = q.purge;
  assign compensate   = q.comp;
  assign power_off    = q.power_off;

endmodule
`default_nettype wire

/* File: verification/hda_annunciator_checker.sv */
// Port-level assertions of the heater diagnostic annunciator
`timescale 1ns/1ps
`default_nettype none
module hda_annunciator_checker #(
  parameter int unsigned MS_CYC = hda_pkg::MS_CYC  // Cycles per tick
) (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       fault_pulse,
  input wire logic       fault_shutdown,
  input wire logic [4:0] disp_hi,
  input wire logic [4:0] disp_lo,
  input wire logic       lamp,
  input wire logic       heat_stop,
  input wire logic       purge_active,
  input wire logic       compensate
);
  localparam int unsigned Q_CYC = hda_pkg::QUICK_MS * MS_CYC;  // Quick phase length
  localparam int unsigned D_CYC = hda_pkg::DARK_MS * MS_CYC;   // Dark gap length
  logic [31:0] on_cnt;   // Lamp-high cycles inside purge
  logic [31:0] off_cnt;  // Lamp-low cycles inside purge
  logic        armed;    // A whole phase seen; the entry phase may be partial

  // Phase counters, cleared outside purge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_cnt  <= '0;
      off_cnt <= '0;
      armed   <= 1'b0;
    end
    else if (!purge_active)
    begin
      on_cnt  <= '0;
      off_cnt <= '0;
      armed   <= 1'b0;
    end
    else
    begin
      on_cnt  <= lamp ? on_cnt + 32'h0000_0001 : '0;
      off_cnt <= lamp ? '0 : off_cnt + 32'h0000_0001;
      if (!lamp && on_cnt != '0)
        armed <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_purge_no_heat; purge_active |-> heat_stop; endproperty
  a_purge_no_heat: assert property (p_purge_no_heat) else $error("heat in purge");
  property p_shut_purge; fault_pulse && fault_shutdown && !heat_stop |-> ##[1:4] purge_active;
  endproperty
  a_shut_purge: assert property (p_shut_purge) else $error("no purge on shutdown");
  property p_comp_run; $rose(compensate) |-> !heat_stop && !purge_active; endproperty
  a_comp_run: assert property (p_comp_run) else $error("compensate outside run");
  property p_run_code;
    lamp && $past(lamp, 2) && !heat_stop && !compensate && !$past(compensate, 2) |->
      {disp_hi, disp_lo} == 10'h007 || {disp_hi, disp_lo} == 10'h024;
  endproperty
  a_run_code: assert property (p_run_code) else $error("bad run code");
  property p_steady; lamp && $past(lamp) && purge_active && $past(purge_active, 2) |->
    $stable(disp_hi) && $stable(disp_lo); endproperty
  a_steady: assert property (p_steady) else $error("fault code not steady");
  property p_on_phase; !lamp && on_cnt != '0 && armed && purge_active |-> on_cnt == Q_CYC;
  endproperty
  a_on_phase: assert property (p_on_phase) else $error("bad flash on time");
  property p_off_phase; $rose(lamp) && armed && purge_active |->
    off_cnt == Q_CYC || off_cnt == D_CYC; endproperty
  a_off_phase: assert property (p_off_phase) else $error("bad flash gap");
  property p_lamp_mode; lamp |-> !heat_stop || purge_active; endproperty
  a_lamp_mode: assert property (p_lamp_mode) else $error("lamp lit when idle");
endmodule

bind hda_annunciator hda_annunciator_checker #(.MS_CYC(MS_CYC)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .fault_pulse(fault_pulse), .fault_shutdown(fault_shutdown),
  .disp_hi(disp_hi), .disp_lo(disp_lo), .lamp(lamp), .heat_stop(heat_stop),
  .purge_active(purge_active), .compensate(compensate)
);
`default_nettype wire

/* File: verification/hda_ctrl_box.sv */
// Control box model: three-position switch, heat level switch, lamp watcher
`timescale 1ns/1ps
`default_nettype none
module hda_ctrl_box #(
  parameter int unsigned MS_CYC = 1  // Cycles per tick
) (
  input  wire logic mclk,
  output var logic  switch_start,
  output var logic  switch_run,
  output var logic  heat_level_switch,
  input  wire logic lamp
);
  initial
  begin
    switch_start      = 1'b0;
    switch_run        = 1'b0;
    heat_level_switch = 1'b0;
  end

  // Start held, then released; run closes first so its level settles before release
  task automatic hold_start(input int ms, input bit to_run);
    @(posedge mclk);
    switch_start <= 1'b1;
    repeat (ms * MS_CYC) @(posedge mclk);
    switch_run <= to_run;
    repeat (8) @(posedge mclk);
    switch_start <= 1'b0;
  endtask

  // Switch to off; caller holds it there
  task automatic go_off;
    switch_run <= 1'b0;
  endtask

  task automatic set_level(input bit hi);
    heat_level_switch <= hi;
  endtask

  // Counts lamp rises over a window, as an operator watching the box would
  task automatic count_rises(input int ms, output int n);
    logic prev;
    n = 0;
    prev = lamp;
    repeat (ms * MS_CYC)
    begin
      @(posedge mclk);
      if (lamp === 1'b1 && prev === 1'b0)
        n++;
      prev = lamp;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/test_heater_diag_annunciator.sv */
// Self-checking testbench of the heater diagnostic annunciator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module test_heater_diag_annunciator;
  localparam int unsigned MS = 1;  // One cycle per tick keeps the run short
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sw_start, sw_run, sw_level;  // Driven by the control box model
  logic [3:0]  design_iteration = 4'h3;
  logic [15:0] hours_bcd = 16'h1234;
  logic [15:0] starts_bcd = 16'h2217;
  logic [7:0]  version_bcd = 8'h02;
  logic        fault_pulse = 1'b0;
  logic [7:0]  fault_code = 8'h00;
  logic        fault_shutdown = 1'b0;
  logic        warn_fatal = 1'b0;
  logic        ignition_done = 1'b0;
  logic [4:0]  disp_hi, disp_lo;
  logic        lamp, heat_stop, purge_active, compensate, power_off;
  int          error_cnt = 0;
  int          compares = 0;

  always #2.5 mclk = ~mclk;

  hda_annunciator #(.MS_CYC(MS)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .switch_start(sw_start), .switch_run(sw_run),
    .heat_level_switch(sw_level), .design_iteration(design_iteration),
    .hours_bcd(hours_bcd), .starts_bcd(starts_bcd), .version_bcd(version_bcd),
    .fault_pulse(fault_pulse), .fault_code(fault_code), .fault_shutdown(fault_shutdown),
    .warn_fatal(warn_fatal), .ignition_done(ignition_done), .disp_hi(disp_hi),
    .disp_lo(disp_lo), .lamp(lamp), .heat_stop(heat_stop), .purge_active(purge_active),
    .compensate(compensate), .power_off(power_off)
  );
  hda_ctrl_box #(.MS_CYC(MS)) u_box (
    .mclk(mclk), .switch_start(sw_start), .switch_run(sw_run),
    .heat_level_switch(sw_level), .lamp(lamp)
  );

  // Two hex digits as glyph pair
  function automatic logic [9:0] gl(input logic [7:0] c);
    return {1'b0, c[7:4], 1'b0, c[3:0]};
  endfunction

  task automatic wt(input int n);
    repeat (n * MS) @(posedge mclk);
  endtask

  // Reset pulse; purge never ends inside this run, so each scenario starts here
  task automatic do_reset(input logic [3:0] iter);
    rst_n <= 1'b0;
    design_iteration <= iter;
    warn_fatal <= 1'b0;
    u_box.set_level(1'b0);
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    wt(10);
  endtask

  task automatic fault(input logic [7:0] code, input logic shut);
    fault_pulse <= 1'b1;
    fault_code <= code;
    fault_shutdown <= shut;
    @(posedge mclk);
    fault_pulse <= 1'b0;
  endtask

  task automatic start_run;
    u_box.hold_start(1200, 1'b1);
    wt(100);
    ignition_done <= 1'b1;
    @(posedge mclk);
    ignition_done <= 1'b0;
    wt(100);
  endtask

  task automatic t_playback(input logic [3:0] iter);
    logic [4:0] dg;
    logic [9:0] exp [8];
    do_reset(iter);
    dg = (iter >= hda_pkg::ITER_LOWER) ? hda_pkg::GLY_D_LO : hda_pkg::GLY_D_UP;
    exp = '{{dg, 5'h01}, gl(hours_bcd[15:8]), gl(hours_bcd[7:0]), {dg, 5'h02},
            gl(starts_bcd[15:8]), gl(starts_bcd[7:0]), {dg, 5'h03}, gl(version_bcd)};
    u_box.hold_start(900, 1'b0);
    wt(500);
    `CHK({disp_hi, disp_lo}, {hda_pkg::GLY_BLANK, hda_pkg::GLY_BLANK})
    u_box.hold_start(1200, 1'b0);
    wt(500);
    for (int k = 0; k < 8; k++)
    begin
      `CHK({disp_hi, disp_lo}, exp[k])
      wt(1000);
      `CHK({disp_hi, disp_lo}, {hda_pkg::GLY_BLANK, hda_pkg::GLY_BLANK})
      wt(1000);
    end
  endtask

  // Run, warning, then a shutdown fault or an unrecoverable warning
  task automatic t_run(input logic shut);
    logic [1:0] seen;
    int         n;
    do_reset(4'h3);
    start_run;
    `CHK({disp_hi, disp_lo, lamp, heat_stop}, {gl(hda_pkg::CODE_LOW), 2'h2})
    u_box.set_level(1'b1);
    wt(50);
    `CHK({disp_hi, disp_lo}, gl(hda_pkg::CODE_HIGH))
    fault(8'hF3, 1'b0);
    wt(100);
    `CHK({compensate, purge_active}, 2'h2)
    seen = 2'h0;
    repeat (10)
    begin
      wt(250);
      if ({disp_hi, disp_lo} === gl(8'hF3))
        seen[0] = 1'b1;
      if ({disp_hi, disp_lo} === gl(hda_pkg::CODE_HIGH))
        seen[1] = 1'b1;
    end
    `CHK(seen, 2'h3)
    if (shut)
      fault(8'hC1, 1'b1);
    else
      warn_fatal <= 1'b1;
    wt(20);
    `CHK({purge_active, heat_stop, compensate}, 3'h6)
    wt(500);
    `CHK({disp_hi, disp_lo}, gl(shut ? 8'hC1 : 8'hF3))
    u_box.count_rises(2250, n);
    `CHK(n, shut ? 1 : 0)
  endtask

  task automatic t_start_fault(input logic [7:0] code, input logic shut, input logic [3:0] iter,
                               input int n, input int period, input logic [9:0] exp);
    int got;
    do_reset(iter);
    u_box.hold_start(1200, 1'b1);
    wt(100);
    fault(code, shut);
    wt(20);
    `CHK({purge_active, heat_stop}, 2'h3)
    wt(300);
    `CHK({disp_hi, disp_lo}, exp)
    u_box.count_rises(period, got);
    `CHK(got, n)
  endtask

  task automatic t_off;
    do_reset(4'h3);
    start_run;
    u_box.go_off;
    wt(1900);
    `CHK(purge_active, 1'b0)
    wt(300);
    `CHK({purge_active, heat_stop}, 2'h3)
    wt(1000);
    `CHK({disp_hi, disp_lo}, gl(hda_pkg::CODE_PURGE))
  endtask

  // Start held past the purge hold, released to off: manual purge
  task automatic t_manual;
    do_reset(4'h3);
    u_box.hold_start(10100, 1'b0);
    wt(100);
    `CHK({purge_active, heat_stop, lamp, power_off}, 4'hC)
    `CHK({disp_hi, disp_lo}, gl(hda_pkg::CODE_PURGE))
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short
  initial
  begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    final_report;
  end

  initial
  begin
    t_playback(4'h3);
    t_playback(4'h0);
    t_run(1'b1);
    t_run(1'b0);
    t_start_fault(8'hE2, 1'b0, 4'h3, 2, 2750, gl(8'hE2));
    t_start_fault(8'hC7, 1'b0, 4'h3, 3, 3250, gl(8'hC7));
    t_start_fault(8'hE6, 1'b1, 4'h0, 1, 2250, {hda_pkg::GLY_BLANK, hda_pkg::GLY_BLANK});
    t_start_fault(8'hE6, 1'b1, 4'h3, 1, 2250, gl(8'hE6));
    t_off;
    t_manual;
    final_report;
  end
endmodule
`default_nettype wire
